// [hdl/tsw_regs.svh]
/*
 temperature switch output logic: register offsets, field positions, reset values, timing counts.
 assumes 32-bit apb with byte addresses, one aligned word per register.
*/
`ifndef TSW_REGS_SVH
`define TSW_REGS_SVH

`define TSW_CLK_HZ 250000000
`define TSW_DELAY_MAX_S 50
`define TSW_TICK_US 100000
`define TSW_TICK_CYC ((`TSW_CLK_HZ / 1000000) * `TSW_TICK_US)

`define TSW_OFF_SW0 12'h000
`define TSW_OFF_RL0 12'h004
`define TSW_OFF_DLY0 12'h008
`define TSW_OFF_FN0 12'h00c
`define TSW_OFF_SW1 12'h010
`define TSW_OFF_RL1 12'h014
`define TSW_OFF_DLY1 12'h018
`define TSW_OFF_FN1 12'h01c
`define TSW_OFF_ASCALE 12'h020
`define TSW_OFF_OFS 12'h024
`define TSW_OFF_DISP 12'h028
`define TSW_OFF_CODE 12'h02c
`define TSW_OFF_CMD 12'h030
`define TSW_OFF_STAT 12'h034
`define TSW_OFF_TEMP 12'h038
`define TSW_OFF_MIN 12'h03c
`define TSW_OFF_MAX 12'h040
`define TSW_OFF_RANGE 12'h044
`define TSW_OFF_TAG 12'h080

`define TSW_CMD_MMCLR 0
`define TSW_CMD_FACT 1
`define TSW_CMD_NCLR 2

`define TSW_STAT_OUT0 0
`define TSW_STAT_OUT1 1
`define TSW_STAT_NOTICE 2
`define TSW_STAT_OVER 3
`define TSW_STAT_UNDER 4
`define TSW_STAT_LOCK 5

`define TSW_RST_SW 16'sh0064
`define TSW_RST_RL 16'sh005a
`define TSW_RST_RMIN 16'shff38
`define TSW_RST_RMAX 16'sh03e8
`define TSW_RST_ASCALE 32'h03e8ff38
`define TSW_RST_CODE 16'h0000

`endif

// [hdl/tsw_pkg.sv]
/*
 temperature switch output logic: shared types.
 assumes tsw_regs.svh for numbers.
*/
`default_nettype none
package tsw_pkg;
	typedef enum logic [1:0] {
		TSW_HNO,
		TSW_HNC,
		TSW_WNO,
		TSW_WNC
	} tsw_func_t;
	typedef struct packed {
		logic signed [15:0] sw_thr;
		logic signed [15:0] rl_thr;
		logic [5:0] act_dly;
		logic [5:0] rel_dly;
		tsw_func_t func;
	} tsw_chan_cfg_t;
	typedef struct packed {
		logic [2:0] src;
		logic rotate;
	} tsw_disp_t;
	typedef enum logic [1:0] {
		TSW_RELEASED,
		TSW_ARMING,
		TSW_ACTIVE,
		TSW_DISARMING
	} tsw_out_state_t;
endpackage
`default_nettype wire

// [hdl/tsw_output_logic.sv]
/*
 temperature switch output logic: two switching outputs, offset, scaling, min/max,
 display select, access code, tag store, range flags, apb register slave.
 assumes a signed 16-bit temperature sample in tenths of a degree on the same clock,
 and an apb master with 32-bit data.
*/
// Decided for this implementation: register access over APB and the register addresses.
`default_nettype none
`include "tsw_regs.svh"

module tsw_output_logic import tsw_pkg::*; #(
	parameter int TICK_CYC = `TSW_TICK_CYC,
	parameter int N_OUT = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// measurement
	input wire logic signed [15:0] temp_i,
	input wire logic temp_valid_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// outputs
	output logic [N_OUT-1:0] switch_o,
	output logic [15:0] analog_o,
	output logic signed [15:0] display_o,
	output logic display_blank_o,
	output logic display_rotate_o,
	output logic display_blink_o,
	output logic notice_o,
	output logic locked_o
);
	if (N_OUT != 2 || TICK_CYC < 1) begin : g_bad_param
		$error("tsw_output_logic: unsupported parameters");
	end
	localparam logic [5:0] DLY_MAX = 6'(`TSW_DELAY_MAX_S);
	function automatic logic is_open(input tsw_func_t f);
		return f == TSW_HNO || f == TSW_WNO;
	endfunction

	// configuration state
	tsw_chan_cfg_t cfg [N_OUT], next_cfg [N_OUT];
	logic signed [15:0] rng_min, rng_max, next_rng_min, next_rng_max;
	logic [31:0] ascale, next_ascale;
	logic signed [15:0] ofs, next_ofs;
	tsw_disp_t disp, next_disp;
	logic [15:0] code, next_code;
	logic [7:0] tag [16], next_tag [16];
	logic notice, next_notice;
	logic signed [15:0] tmin, tmax, next_tmin, next_tmax;
	logic mm_valid, next_mm_valid;
	logic [31:0] prdata, next_prdata;
	logic pready, next_pready, pslverr, next_pslverr;
	logic signed [15:0] temp_c;
	logic range_over, range_under;
	wire acc = psel_i && penable_i && !pready;
	wire wr = psel_i && penable_i && pready && pwrite_i;

	// offset limit: 3 % of span
	logic signed [17:0] span, ofs_lim, wofs;
	always_comb begin
		span = 18'(rng_max) - 18'(rng_min);
		ofs_lim = 18'((span * 3) / 100);
		wofs = 18'(signed'(pwdata_i[15:0]));
		if (wofs > ofs_lim)
			wofs = ofs_lim;
		else if (wofs < -ofs_lim)
			wofs = -ofs_lim;
	end

	always_comb begin
		for (int i = 0; i < N_OUT; i++)
			next_cfg[i] = cfg[i];
		next_rng_min = rng_min;
		next_rng_max = rng_max;
		next_ascale = ascale;
		next_ofs = ofs;
		next_disp = disp;
		next_code = code;
		next_tag = tag;
		next_notice = notice;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		if (acc) begin
			next_pready = 1'b1;
			next_prdata = 32'h0;
			case (paddr_i)
			`TSW_OFF_SW0, `TSW_OFF_SW1: next_prdata = 32'(cfg[paddr_i[4]].sw_thr);
			`TSW_OFF_RL0, `TSW_OFF_RL1: next_prdata = 32'(cfg[paddr_i[4]].rl_thr);
			`TSW_OFF_DLY0, `TSW_OFF_DLY1: next_prdata = {18'h0, cfg[paddr_i[4]].rel_dly,
				2'h0, cfg[paddr_i[4]].act_dly};
			`TSW_OFF_FN0, `TSW_OFF_FN1: next_prdata = {30'h0, cfg[paddr_i[4]].func};
			`TSW_OFF_ASCALE: next_prdata = ascale;
			`TSW_OFF_OFS: next_prdata = 32'(ofs);
			`TSW_OFF_DISP: next_prdata = {27'h0, disp.rotate, 1'b0, disp.src};
			`TSW_OFF_CODE: next_prdata = 32'h0;
			`TSW_OFF_CMD: next_prdata = 32'h0;
			`TSW_OFF_STAT: next_prdata = {26'h0, code != 16'h0, range_under, range_over,
				notice, switch_o[1], switch_o[0]};
			`TSW_OFF_TEMP: next_prdata = 32'(temp_c);
			`TSW_OFF_MIN: next_prdata = 32'(tmin);
			`TSW_OFF_MAX: next_prdata = 32'(tmax);
			`TSW_OFF_RANGE: next_prdata = {rng_max, rng_min};
			default: begin
				if (paddr_i[11:6] == `TSW_OFF_TAG >> 6 && paddr_i[5:4] == 2'h0)
					next_prdata = {tag[{paddr_i[3:2], 2'd3}], tag[{paddr_i[3:2], 2'd2}],
						tag[{paddr_i[3:2], 2'd1}], tag[{paddr_i[3:2], 2'd0}]};
				else
					next_pslverr = 1'b1;
			end
			endcase
		end
		if (wr) begin
			case (paddr_i)
			`TSW_OFF_SW0, `TSW_OFF_SW1: begin
				next_cfg[paddr_i[4]].sw_thr = signed'(pwdata_i[15:0]);
				if (cfg[paddr_i[4]].rl_thr >= signed'(pwdata_i[15:0])) begin
					next_cfg[paddr_i[4]].rl_thr = signed'(pwdata_i[15:0]) - 16'sd1;
					next_notice = 1'b1;
				end
			end
			`TSW_OFF_RL0, `TSW_OFF_RL1:
				next_cfg[paddr_i[4]].rl_thr = signed'(pwdata_i[15:0]);
			`TSW_OFF_DLY0, `TSW_OFF_DLY1: begin
				next_cfg[paddr_i[4]].act_dly = pwdata_i[5:0] > DLY_MAX ? DLY_MAX
					: pwdata_i[5:0];
				next_cfg[paddr_i[4]].rel_dly = pwdata_i[13:8] > DLY_MAX ? DLY_MAX
					: pwdata_i[13:8];
			end
			`TSW_OFF_FN0, `TSW_OFF_FN1: next_cfg[paddr_i[4]].func = tsw_func_t'(pwdata_i[1:0]);
			`TSW_OFF_ASCALE: next_ascale = pwdata_i;
			`TSW_OFF_OFS: next_ofs = wofs[15:0];
			`TSW_OFF_DISP: next_disp = '{src: pwdata_i[2:0], rotate: pwdata_i[4]};
			`TSW_OFF_CODE: next_code = pwdata_i[15:0];
			`TSW_OFF_RANGE: begin
				next_rng_min = signed'(pwdata_i[15:0]);
				next_rng_max = signed'(pwdata_i[31:16]);
			end
			`TSW_OFF_CMD: begin
				if (pwdata_i[`TSW_CMD_NCLR])
					next_notice = 1'b0;
				if (pwdata_i[`TSW_CMD_FACT]) begin
					for (int i = 0; i < N_OUT; i++)
						next_cfg[i] = '{`TSW_RST_SW, `TSW_RST_RL, 6'h0, 6'h0, TSW_HNO};
					next_ascale = `TSW_RST_ASCALE;
					next_ofs = 16'sh0;
					next_disp = '{3'h0, 1'b0};
					next_code = `TSW_RST_CODE;
					for (int i = 0; i < 16; i++)
						next_tag[i] = 8'h20;
				end
			end
			default: begin
				if (paddr_i[11:6] == `TSW_OFF_TAG >> 6 && paddr_i[5:4] == 2'h0)
					for (int b = 0; b < 4; b++)
						next_tag[{paddr_i[3:2], 2'(b)}] = pwdata_i[8*b +: 8];
			end
			endcase
		end
	end

	// measurement path
	logic signed [17:0] marg;
	always_comb begin
		temp_c = temp_i + ofs;
		marg = 18'(span / 20);
		range_over = 18'(temp_c) > 18'(rng_max) + marg;
		range_under = 18'(temp_c) < 18'(rng_min) - marg;
	end

	always_comb begin
		next_tmin = tmin;
		next_tmax = tmax;
		next_mm_valid = mm_valid;
		if (temp_valid_i) begin
			next_mm_valid = 1'b1;
			if (!mm_valid || temp_c < tmin)
				next_tmin = temp_c;
			if (!mm_valid || temp_c > tmax)
				next_tmax = temp_c;
		end
		if (wr && paddr_i == `TSW_OFF_CMD && pwdata_i[`TSW_CMD_MMCLR]) begin
			next_mm_valid = 1'b0;
			next_tmin = 16'sh0;
			next_tmax = 16'sh0;
		end
	end
	// tenth-of-a-second tick
	logic [31:0] tick_cnt, next_tick_cnt;
	logic tick;
	always_comb begin
		tick = tick_cnt == 32'(TICK_CYC - 1);
		next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
	end
	// output channels
	tsw_out_state_t st [N_OUT], next_st [N_OUT];
	logic [9:0] dcnt [N_OUT], next_dcnt [N_OUT];
	logic [N_OUT-1:0] next_sw;
	generate
		for (genvar g = 0; g < N_OUT; g++) begin : g_ch
			logic set_c, clr_c, act_c;
			logic [9:0] act_t, rel_t;
			always_comb begin
				if (cfg[g].func == TSW_HNO || cfg[g].func == TSW_HNC) begin
					set_c = temp_c >= cfg[g].sw_thr;
					clr_c = temp_c <= cfg[g].rl_thr;
				end else begin
					set_c = temp_c >= cfg[g].rl_thr && temp_c <= cfg[g].sw_thr;
					clr_c = !set_c;
				end
				act_t = 10'(cfg[g].act_dly) * 10'd10;
				rel_t = 10'(cfg[g].rel_dly) * 10'd10;
				next_st[g] = st[g];
				next_dcnt[g] = dcnt[g];
				case (st[g])
				TSW_RELEASED: if (set_c) begin
					next_st[g] = act_t == 10'h0 ? TSW_ACTIVE : TSW_ARMING;
					next_dcnt[g] = 10'h0;
				end
				TSW_ARMING: if (!set_c)
					next_st[g] = TSW_RELEASED;
				else if (tick) begin
					next_dcnt[g] = dcnt[g] + 10'h1;
					if (dcnt[g] + 10'h1 >= act_t)
						next_st[g] = TSW_ACTIVE;
				end
				TSW_ACTIVE: if (clr_c) begin
					next_st[g] = rel_t == 10'h0 ? TSW_RELEASED : TSW_DISARMING;
					next_dcnt[g] = 10'h0;
				end
				TSW_DISARMING: if (!clr_c)
					next_st[g] = TSW_ACTIVE;
				else if (tick) begin
					next_dcnt[g] = dcnt[g] + 10'h1;
					if (dcnt[g] + 10'h1 >= rel_t)
						next_st[g] = TSW_RELEASED;
				end
				default: next_st[g] = TSW_RELEASED;
				endcase
				act_c = next_st[g] == TSW_ACTIVE || next_st[g] == TSW_DISARMING;
				next_sw[g] = is_open(cfg[g].func) ? act_c : !act_c;
			end
		end
	endgenerate
	// display and analog
	logic signed [15:0] next_display;
	logic next_blank;
	logic [15:0] next_analog;
	logic signed [31:0] anum, aden;
	always_comb begin
		next_blank = 1'b0;
		case (disp.src)
		3'd0: next_display = temp_c;
		3'd1: next_display = tmin;
		3'd2: next_display = tmax;
		3'd4: next_display = cfg[0].sw_thr;
		3'd5: next_display = cfg[0].rl_thr;
		3'd6: next_display = cfg[1].sw_thr;
		3'd7: next_display = cfg[1].rl_thr;
		default: begin
			next_display = 16'sh0;
			next_blank = 1'b1;
		end
		endcase
		aden = 32'(signed'(ascale[31:16])) - 32'(signed'(ascale[15:0]));
		anum = (32'(temp_c) - 32'(signed'(ascale[15:0]))) * 32'sd65535;
		if (aden == 32'sh0 || anum <= 32'sh0)
			next_analog = 16'h0;
		else if (anum >= aden * 32'sd65535)
			next_analog = 16'hffff;
		else
			next_analog = 16'(anum / aden);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < N_OUT; i++) begin
				cfg[i] <= '{`TSW_RST_SW, `TSW_RST_RL, 6'h0, 6'h0, TSW_HNO};
				st[i] <= TSW_RELEASED;
				dcnt[i] <= 10'h0;
			end
			for (int i = 0; i < 16; i++)
				tag[i] <= 8'h20;
			rng_min <= `TSW_RST_RMIN;
			rng_max <= `TSW_RST_RMAX;
			ascale <= `TSW_RST_ASCALE;
			ofs <= 16'sh0;
			disp <= '{3'h0, 1'b0};
			code <= `TSW_RST_CODE;
			notice <= 1'b0;
			tmin <= 16'sh0;
			tmax <= 16'sh0;
			mm_valid <= 1'b0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			tick_cnt <= 32'h0;
			switch_o <= '0;
			analog_o <= 16'h0;
			display_o <= 16'sh0;
			display_blank_o <= 1'b0;
			display_rotate_o <= 1'b0;
			display_blink_o <= 1'b0;
			notice_o <= 1'b0;
			locked_o <= 1'b0;
		end else if (ce_i) begin
			cfg <= next_cfg;
			st <= next_st;
			dcnt <= next_dcnt;
			tag <= next_tag;
			rng_min <= next_rng_min;
			rng_max <= next_rng_max;
			ascale <= next_ascale;
			ofs <= next_ofs;
			disp <= next_disp;
			code <= next_code;
			notice <= next_notice;
			tmin <= next_tmin;
			tmax <= next_tmax;
			mm_valid <= next_mm_valid;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			tick_cnt <= next_tick_cnt;
			switch_o <= next_sw;
			analog_o <= next_analog;
			display_o <= next_display;
			display_blank_o <= next_blank;
			display_rotate_o <= disp.rotate;
			display_blink_o <= range_over || range_under;
			notice_o <= notice;
			locked_o <= code != 16'h0;
		end
	end

	assign prdata_o = prdata;
	assign pready_o = pready;
	assign pslverr_o = pslverr;
endmodule
`default_nettype wire

// [testbench/tsw_output_logic_properties.sv]
/*
 checker for tsw_output_logic: apb handshake, clock enable and register-driven outputs.
 assumes it is bound to the design's top module and sees only its ports.
*/
`default_nettype none
module tsw_output_logic_properties #(
	parameter int N_OUT = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// outputs
	input wire logic [N_OUT-1:0] switch_o,
	input wire logic [15:0] analog_o,
	input wire logic notice_o,
	input wire logic locked_o,
	input wire logic display_rotate_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence access_taken;
		psel_i && penable_i && !pready_o && ce_i;
	endsequence
	sequence write_done;
		$past(pready_o && pwrite_i && !pslverr_o, 2);
	endsequence
	pready_once_a: assert property (pready_o |=> !pready_o)
		else $error("pready high for more than one cycle");
	pready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i && ce_i))
		else $error("pready without an access phase");
	answer_due_a: assert property (access_taken |=> pready_o)
		else $error("access phase not answered in one cycle");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");
	ce_freeze_a: assert property (!ce_i |=> $stable({switch_o, analog_o, notice_o, locked_o}))
		else $error("outputs moved while clock enable low");
	lock_write_a: assert property ($changed(locked_o) |-> write_done)
		else $error("lock changed without a register write");
	notice_write_a: assert property ($rose(notice_o) |-> write_done)
		else $error("notice raised without a register write");
	rotate_write_a: assert property ($changed(display_rotate_o) |-> write_done)
		else $error("rotation changed without a register write");
endmodule
bind tsw_output_logic tsw_output_logic_properties #(.N_OUT(N_OUT)) i_props (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .switch_o(switch_o), .analog_o(analog_o),
	.notice_o(notice_o), .locked_o(locked_o), .display_rotate_o(display_rotate_o));
`default_nettype wire

// [testbench/tb_top.sv]
/*
 testbench for tsw_output_logic: apb master tasks, function table, delays, side registers.
 assumes the design package and register header are compiled first.
*/
`default_nettype none
`include "tsw_regs.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top import tsw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {tsw_func_t f; logic [15:0] t; logic x;} tsw_row_t;
	tsw_row_t rows[14] = '{'{TSW_HNO, 50, 0}, '{TSW_HNO, 100, 1}, '{TSW_HNO, 95, 1},
		'{TSW_HNO, 90, 0}, '{TSW_HNO, 95, 0}, '{TSW_HNC, 50, 1}, '{TSW_HNC, 100, 0},
		'{TSW_HNC, 95, 0}, '{TSW_HNC, 90, 1}, '{TSW_WNO, 50, 0}, '{TSW_WNO, 95, 1},
		'{TSW_WNO, 120, 0}, '{TSW_WNC, 95, 0}, '{TSW_WNC, 120, 1}};
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ce_i = 1'b1;
	logic temp_valid_i = 1'b1;
	logic signed [15:0] temp_i = 16'sh0032;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o, rd;
	logic pready_o, pslverr_o, err, display_blank_o, display_rotate_o;
	logic display_blink_o, notice_o, locked_o;
	logic [1:0] switch_o;
	logic [15:0] analog_o;
	logic signed [15:0] display_o;
	int compares = 0;
	int miscompares = 0;
	always #2 clk_i = ~clk_i;
	tsw_output_logic #(.TICK_CYC(10)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.temp_i(temp_i), .temp_valid_i(temp_valid_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .switch_o(switch_o), .analog_o(analog_o),
		.display_o(display_o), .display_blank_o(display_blank_o),
		.display_rotate_o(display_rotate_o), .display_blink_o(display_blink_o),
		.notice_o(notice_o), .locked_o(locked_o));
	task report_and_stop;
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// the answer is taken at the rising edge, before that edge's updates land
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (pready_o !== 1'b1) begin
			miscompares++;
			report_and_stop();
		end
	endtask
	task automatic tstep(input logic signed [15:0] t, input int n);
		@(posedge clk_i);
		temp_i <= t;
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	initial begin
		repeat (100000) @(posedge clk_i);
		miscompares++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		apb(0, `TSW_OFF_SW0, 0);
		`CHK("sw0 reset", 16'h0064, rd[15:0])
		apb(0, `TSW_OFF_RL0, 0);
		`CHK("rl0 reset", 16'h005a, rd[15:0])
		`CHK("lock reset", 1'b0, locked_o)
		foreach (rows[i]) begin
			if (i == 0 || rows[i].f != rows[i-1].f)
				apb(1, `TSW_OFF_FN0, {30'h0, rows[i].f});
			tstep(rows[i].t, 4);
			`CHK("row switch", rows[i].x, switch_o[0])
		end
		// channel 0 waits one second each way, channel 1 switches at once
		apb(1, `TSW_OFF_FN0, 0);
		apb(1, `TSW_OFF_DLY0, 32'h101);
		tstep(50, 250);
		`CHK("released", 2'b00, switch_o)
		tstep(100, 50);
		`CHK("act pending", 2'b10, switch_o)
		tstep(50, 10);
		tstep(100, 90);
		`CHK("act restart", 1'b0, switch_o[0])
		tstep(100, 30);
		`CHK("act done", 1'b1, switch_o[0])
		tstep(80, 50);
		`CHK("rel pending", 2'b01, switch_o)
		tstep(80, 70);
		`CHK("rel done", 2'b00, switch_o)
		@(posedge clk_i) temp_valid_i <= 1'b0;
		apb(1, `TSW_OFF_CMD, 32'h1);
		apb(0, `TSW_OFF_MIN, 0);
		`CHK("min clear", 16'h0000, rd[15:0])
		@(posedge clk_i) temp_valid_i <= 1'b1;
		tstep(60, 4);
		tstep(130, 4);
		@(posedge clk_i) temp_valid_i <= 1'b0;
		apb(0, `TSW_OFF_MIN, 0);
		`CHK("min", 16'h003c, rd[15:0])
		apb(0, `TSW_OFF_MAX, 0);
		`CHK("max", 16'h0082, rd[15:0])
		tstep(1100, 6);
		`CHK("over", 1'b1, display_blink_o)
		`CHK("analog top", 16'hffff, analog_o)
		tstep(-300, 6);
		`CHK("under", 1'b1, display_blink_o)
		`CHK("analog low", 16'h0000, analog_o)
		tstep(50, 6);
		`CHK("in range", 1'b0, display_blink_o)
		apb(1, `TSW_OFF_SW0, 80);
		apb(0, `TSW_OFF_RL0, 0);
		`CHK("rl lowered", 16'h004f, rd[15:0])
		`CHK("notice", 1'b1, notice_o)
		apb(1, `TSW_OFF_CMD, 32'h4);
		apb(0, `TSW_OFF_SW0, 0);
		`CHK("notice clr", 1'b0, notice_o)
		apb(1, `TSW_OFF_CODE, 32'h1234);
		apb(0, `TSW_OFF_STAT, 0);
		`CHK("locked", 1'b1, locked_o)
		apb(1, `TSW_OFF_CODE, 0);
		apb(0, `TSW_OFF_STAT, 0);
		`CHK("unlocked", 1'b0, locked_o)
		apb(1, `TSW_OFF_DISP, 32'h14);
		apb(0, `TSW_OFF_STAT, 0);
		`CHK("disp sw0", 16'h0050, display_o)
		`CHK("rotate", 1'b1, display_rotate_o)
		apb(1, `TSW_OFF_DISP, 32'h3);
		apb(0, `TSW_OFF_STAT, 0);
		`CHK("blank", 1'b1, display_blank_o)
		apb(1, `TSW_OFF_OFS, 32'h64);
		apb(0, `TSW_OFF_OFS, 0);
		`CHK("ofs clamp", 16'h0024, rd[15:0])
		apb(0, `TSW_OFF_TEMP, 0);
		`CHK("ofs temp", 16'h0056, rd[15:0])
		apb(1, `TSW_OFF_TAG, 32'h44434241);
		apb(0, `TSW_OFF_TAG, 0);
		`CHK("tag", 32'h44434241, rd)
		apb(1, `TSW_OFF_CMD, 32'h2);
		apb(0, `TSW_OFF_SW0, 0);
		`CHK("restored sw0", 16'h0064, rd[15:0])
		apb(0, `TSW_OFF_OFS, 0);
		`CHK("restored ofs", 16'h0000, rd[15:0])
		apb(0, `TSW_OFF_TAG, 0);
		`CHK("restored tag", 32'h20202020, rd)
		`CHK("restored rot", 1'b0, display_rotate_o)
		apb(1, 12'h0f0, 32'hffff);
		`CHK("unmapped err", 1'b1, err)
		apb(0, `TSW_OFF_SW0, 0);
		`CHK("mapped err", 1'b0, err)
		@(posedge clk_i) ce_i <= 1'b0;
		tstep(150, 20);
		`CHK("frozen", 2'b00, switch_o)
		@(posedge clk_i) ce_i <= 1'b1;
		tstep(150, 6);
		`CHK("thawed", 2'b11, switch_o)
		`CHK("analog mid", 16'h4aaa, analog_o)
		// reset again with both outputs active, then release inside the band
		@(posedge clk_i) rst_n_i <= 1'b0;
		tstep(95, 4);
		`CHK("reset switch", 2'b00, switch_o)
		@(posedge clk_i) rst_n_i <= 1'b1;
		tstep(95, 20);
		`CHK("band power up", 2'b00, switch_o)
		report_and_stop();
	end
endmodule
`default_nettype wire
